/* verilog/station_addr_pkg.sv */
// Constants, types and encodings shared by the station address block.
// Assumes a single 100 MHz clock domain with an active-low asynchronous reset.
package station_addr_pkg;

	// ----------------------------------------------------------------
	// Address range and defaults
	// ----------------------------------------------------------------
	localparam logic [6:0]  ADDR_MAX_VALID   = 7'h7D;
	localparam logic [6:0]  ADDR_FACTORY     = 7'h7E;
	localparam logic [15:0] RESET_CODE       = 16'h0A98;

	// ----------------------------------------------------------------
	// Identification selector encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDENT_PROFILE    = 8'h00;
	localparam logic [7:0]  IDENT_NEW_GEN    = 8'h01;
	localparam logic [7:0]  IDENT_AUTO       = 8'h7F;
	localparam logic [7:0]  IDENT_LEGACY     = 8'h80;
	localparam logic [7:0]  IDENT_RESET      = 8'h01;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ           = 100_000_000;
	localparam int          SETTLE_S         = 10;
	localparam longint      SETTLE_CYCLES    = longint'(SETTLE_S) * longint'(CLK_HZ);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_SETTLE,
		ST_RESTART
	} addr_state_e;

endpackage : station_addr_pkg

/* verilog/switch_sync_if.sv */
// Carrier between the switch synchroniser and the address selector.
// Assumes both ends share ref_clk.
`timescale 1ns/1ns
`default_nettype none
interface switch_sync_if;
	logic [7:0] level;
	logic       changed;
	modport src (output level, output changed);
	modport dst (input level, input changed);
endinterface : switch_sync_if
`default_nettype wire

/* verilog/switch_sync.sv */
// Three-stage synchroniser for the eight DIP switch pins.
// Assumes the pins are asynchronous and slow compared to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module switch_sync (
	input  wire logic   ref_clk,
	input  wire logic   rst_b,
	input  wire logic   [7:0] pins,
	switch_sync_if.src  sync
);
	logic [7:0] stage1;
	logic [7:0] stage2;
	logic [7:0] stage3;
	logic [7:0] level;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= 8'h00;
			stage2 <= 8'h00;
			stage3 <= 8'h00;
		end else begin
			stage1 <= pins;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A bit changes only once the second and third stages agree
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					level[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	endgenerate

	assign sync.level   = level;
	assign sync.changed = (stage2 == stage3) && (stage3 != level);
endmodule : switch_sync
`default_nettype wire

/* verilog/station_addr_select.sv */
// Station address selection and identification selector gate.
// Assumes switch pins are asynchronous; bus requests arrive on ref_clk.
//
// Function
// - Only addresses 0..125 are valid (code checks soft writes only; switches can give 126, 127)
// - Delivered with address 126, software source
// - Switch 8 off selects hardware address
// - Hardware address is weighted sum of switches
// - Apply switch change after 10 s, restart
// - Software mode reports stored address, accepts bus
// - Menu refuses 126; code 2712 restores 126
// - Ident write only when cyclic exchange absent
// - Generic profile sends primary value only
// - Ident codes 0, 1, 128, 127 auto
`timescale 1ns/1ns
`default_nettype none
module station_addr_select #(
	parameter longint SETTLE_COUNT = station_addr_pkg::SETTLE_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] dip_switches,
	input  wire logic       bus_set_addr,
	input  wire logic       bus_connected,
	input  wire logic       menu_set_addr,
	input  wire logic [6:0] new_addr,
	input  wire logic       reset_cmd,
	input  wire logic [15:0] reset_code,
	input  wire logic       ident_write,
	input  wire logic [7:0] ident_value,
	input  wire logic       cyclic_active,
	output var  logic [6:0] station_addr,
	output var  logic       address_source_switch,
	output var  logic       addr_set_ack,
	output var  logic       restart_pulse,
	output var  logic [7:0] ident_select,
	output var  logic       ident_write_ack,
	output var  logic       second_cyclic_value,
	output var  logic       third_cyclic_value,
	output var  logic       display_value_en
);
	import station_addr_pkg::*;

	// ----------------------------------------------------------------
	// Switch synchroniser
	// ----------------------------------------------------------------
	switch_sync_if sw ();

	switch_sync u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.pins    (dip_switches),
		.sync    (sw)
	);

	// ----------------------------------------------------------------
	// Settling timer and restart sequencing
	// ----------------------------------------------------------------
	addr_state_e state;
	logic [39:0] settle_cnt;
	logic        boot_done;
	logic [6:0]  stored_addr;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_RESTART;
			settle_cnt <= 40'h00_0000_0000;
		end else begin
			case (state)
				ST_RUN: begin
					// Any switch move restarts the settling wait
					if (sw.changed) begin
						state      <= ST_SETTLE;
						settle_cnt <= 40'h00_0000_0000;
					end
				end
				ST_SETTLE: begin
					if (sw.changed) begin
						settle_cnt <= 40'h00_0000_0000;
					end else if (settle_cnt >= 40'(SETTLE_COUNT - 1)) begin
						state <= ST_RESTART;
					end else begin
						settle_cnt <= settle_cnt + 40'h00_0000_0001;
					end
				end
				ST_RESTART: begin
					state <= ST_RUN;
				end
				default: begin
					state <= ST_RESTART;
				end
			endcase
		end
	end

	// The boot restart comes before the synchroniser holds real levels,
	// so it keeps the delivered source; the first settled change latches
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_done <= 1'b0;
		end else if (state == ST_RESTART) begin
			boot_done <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			restart_pulse <= 1'b0;
		end else begin
			restart_pulse <= (state == ST_RESTART);
		end
	end

	// ----------------------------------------------------------------
	// Address source and address
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			address_source_switch <= 1'b1;
		end else if (state == ST_RESTART && boot_done) begin
			address_source_switch <= sw.level[7];
		end
	end

	logic addr_ok;
	logic menu_ok;
	assign addr_ok = (new_addr <= ADDR_MAX_VALID);
	assign menu_ok = !menu_set_addr || (new_addr != ADDR_FACTORY);

	// Stored soft address survives restarts; only writes and the code change it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stored_addr <= ADDR_FACTORY;
		end else if (reset_cmd && reset_code == RESET_CODE) begin
			stored_addr <= ADDR_FACTORY;
		end else if ((bus_set_addr || menu_set_addr) && address_source_switch
			&& !bus_connected && addr_ok && menu_ok) begin
			stored_addr <= new_addr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_set_ack <= 1'b0;
		end else begin
			addr_set_ack <= (bus_set_addr || menu_set_addr) && address_source_switch
				&& !bus_connected && addr_ok && menu_ok;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			station_addr <= ADDR_FACTORY;
		end else if (state == ST_RESTART && boot_done && !sw.level[7]) begin
			station_addr <= sw.level[6:0];
		end else if (address_source_switch && !(state == ST_RESTART)) begin
			station_addr <= stored_addr;
		end else if (state == ST_RESTART && sw.level[7]) begin
			station_addr <= stored_addr;
		end
	end

	// ----------------------------------------------------------------
	// Identification selector
	// ----------------------------------------------------------------
	logic ident_legal;
	assign ident_legal = (ident_value == IDENT_PROFILE) || (ident_value == IDENT_NEW_GEN)
		|| (ident_value == IDENT_AUTO) || (ident_value == IDENT_LEGACY);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ident_select <= IDENT_RESET;
		end else if (ident_write && !cyclic_active && ident_legal) begin
			ident_select <= ident_value;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ident_write_ack <= 1'b0;
		end else begin
			ident_write_ack <= ident_write && !cyclic_active && ident_legal;
		end
	end

	// Generic profile carries the primary value alone
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			second_cyclic_value <= 1'b1;
			third_cyclic_value  <= 1'b1;
			display_value_en    <= 1'b1;
		end else begin
			second_cyclic_value <= (ident_select != IDENT_PROFILE);
			third_cyclic_value  <= (ident_select != IDENT_PROFILE);
			display_value_en    <= (ident_select != IDENT_PROFILE);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	addr_range_a: assert property (addr_set_ack |-> $past(new_addr) <= ADDR_MAX_VALID)
		else $error("accepted address out of range");
	menu_factory_a: assert property ($past(menu_set_addr) && $past(new_addr) == ADDR_FACTORY
		|-> !addr_set_ack)
		else $error("menu accepted address 126");
	reset_code_a: assert property (reset_cmd && reset_code == RESET_CODE
		|=> stored_addr == ADDR_FACTORY)
		else $error("reset code did not restore default");
	ident_gate_a: assert property (ident_write && cyclic_active |=> $stable(ident_select))
		else $error("ident changed during cyclic exchange");
	ident_legal_a: assert property (ident_select == IDENT_PROFILE || ident_select == IDENT_NEW_GEN
		|| ident_select == IDENT_AUTO || ident_select == IDENT_LEGACY)
		else $error("ident selector holds an illegal code");
	profile_only_a: assert property (ident_select == IDENT_PROFILE
		|=> !second_cyclic_value && !third_cyclic_value && !display_value_en)
		else $error("generic profile sends extra values");
	connected_a: assert property (bus_connected |=> !addr_set_ack)
		else $error("address set while connected");
	hw_addr_a: assert property (state == ST_RESTART && boot_done && !sw.level[7]
		|=> station_addr == $past(sw.level[6:0]))
		else $error("hardware address not the switch sum");
	hold_a: assert property (state == ST_RUN && !address_source_switch
		|=> $stable(station_addr))
		else $error("hardware address moved without restart");
	settle_a: assert property (sw.changed && state == ST_RUN |=> state == ST_SETTLE [*2])
		else $error("switch change skipped the settling wait");

	restart_c: cover property (restart_pulse && !address_source_switch);
	soft_set_c: cover property (addr_set_ack);
	ident_ok_c: cover property (ident_write_ack);
	ident_drop_c: cover property (ident_write && cyclic_active);
endmodule : station_addr_select
`default_nettype wire

/* verification/cfg_master.sv */
// Behavioural configuration master facing the station address block.
// Assumes the bench raises req for exactly one rising edge per request.
`timescale 1ns/1ns
`default_nettype none
module cfg_master (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       req,
	input  wire logic       keep_conn,
	input  wire logic [6:0] req_addr,
	output var  logic       bus_set_addr,
	output var  logic       bus_connected,
	output wire logic [6:0] new_addr
);
	logic pend;

	assign new_addr = req_addr;

	// ----------------------------------------------------------------
	// Disconnect, then set one cycle later
	// ----------------------------------------------------------------
	// Connection comes back only once the set pulse is over, so the block
	// never sees a request while connected unless keep_conn asks for it.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend          <= 1'b0;
			bus_set_addr  <= 1'b0;
			bus_connected <= 1'b1;
		end else begin
			pend         <= req;
			bus_set_addr <= pend;
			if (req) begin
				bus_connected <= keep_conn;
			end else if (bus_set_addr) begin
				bus_connected <= 1'b1;
			end
		end
	end
endmodule : cfg_master
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the station address block.
// Assumes a shortened settle count; the bench drives on falling edges.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import station_addr_pkg::*;

	typedef struct {logic id; logic [7:0] v; logic f; logic ok;} row_s;

	logic ref_clk = 0, rst_b = 0, req = 0, keep = 0, menu = 0, rcmd = 0;
	logic iwr = 0, cyc = 0, set_w, conn, ack, rpulse, src, iack, c2, c3, dsp;
	logic [7:0] dip = 8'h80, ival = 8'h00, isel, sel;
	logic [6:0] raddr = 7'h00, naddr, st, cur;
	logic [15:0] rcode = 16'h0000;
	int errors = 0, total_checks = 0, n;
	row_s rows [12] = '{
		'{0, 8'h05, 0, 1}, '{0, 8'h7D, 0, 1}, '{0, 8'h7E, 0, 0}, '{0, 8'h7F, 0, 0},
		'{0, 8'h00, 0, 1}, '{0, 8'h07, 1, 0}, '{1, 8'h80, 0, 1}, '{1, 8'h7F, 0, 1},
		'{1, 8'h05, 0, 0}, '{1, 8'h00, 1, 0}, '{1, 8'h00, 0, 1}, '{1, 8'h01, 0, 1}};

	always #5 ref_clk = ~ref_clk;

	cfg_master master (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .keep_conn(keep),
		.req_addr(raddr), .bus_set_addr(set_w), .bus_connected(conn), .new_addr(naddr));

	station_addr_select #(.SETTLE_COUNT(20)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.dip_switches(dip), .bus_set_addr(set_w), .bus_connected(conn),
		.menu_set_addr(menu), .new_addr(naddr), .reset_cmd(rcmd), .reset_code(rcode),
		.ident_write(iwr), .ident_value(ival), .cyclic_active(cyc), .station_addr(st),
		.address_source_switch(src), .addr_set_ack(ack), .restart_pulse(rpulse),
		.ident_select(isel), .ident_write_ack(iack), .second_cyclic_value(c2),
		.third_cyclic_value(c3), .display_value_en(dsp));

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task soft_set(input logic [6:0] a, input logic k, input logic ok);
		raddr = a;
		keep = k;
		req = 1;
		@(negedge ref_clk) req = 0;
		repeat (2) @(negedge ref_clk);
		chk(ack, ok);
		if (ok) cur = a;
		@(negedge ref_clk) chk(st, cur);
		keep = 0;
	endtask : soft_set

	task id_wr(input logic [7:0] v, input logic c, input logic ok);
		ival = v;
		cyc = c;
		iwr = 1;
		@(negedge ref_clk) iwr = 0;
		chk(iack, ok);
		if (ok) sel = v;
		chk(isel, sel);
		@(negedge ref_clk) chk({c2, c3, dsp}, {3{sel != 0}});
		cyc = 0;
	endtask : id_wr

	initial begin
		#100000;
		errors++;
		stop_test();
	end

	initial begin
		repeat (8) @(negedge ref_clk);
		chk({st, src, isel}, {ADDR_FACTORY, 1'b1, 8'h01});
		rst_b = 1;
		cur = ADDR_FACTORY;
		sel = 8'h01;
		repeat (8) @(negedge ref_clk);
		chk(st, ADDR_FACTORY);
		foreach (rows[i]) begin
			if (rows[i].id) id_wr(rows[i].v, rows[i].f, rows[i].ok);
			else soft_set(rows[i].v[6:0], rows[i].f, rows[i].ok);
		end
		// Menu write of the factory address must be turned away
		raddr = ADDR_FACTORY;
		menu = 1;
		@(negedge ref_clk) menu = 0;
		chk(ack, 0);
		foreach (rows[i]) if (i < 2) begin
			rcode = i ? RESET_CODE : 16'h0A97;
			rcmd = 1;
			@(negedge ref_clk) rcmd = 0;
			if (i) cur = ADDR_FACTORY;
			@(negedge ref_clk) chk(st, cur);
		end
		dip = 8'h2B;
		repeat (10) @(negedge ref_clk);
		chk(st, cur);
		n = 0;
		while (rpulse !== 1'b1 && n < 100) @(negedge ref_clk) n++;
		chk(n < 100, 1);
		@(negedge ref_clk) chk({st, src}, {7'h2B, 1'b0});
		cur = 7'h2B;
		soft_set(7'h09, 0, 0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
